// ==== dv/wrm_engine_model.sv ====
// Playback engine model that flags the last point of each cycle while playing
`timescale 1ns/1ps
module wrm_engine_model (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Engine control
   input wire logic play,
   input wire logic [7:0] cycle_len,
   // Engine status
   output logic cycle_end
);
   logic [7:0] point_reg;

   // ----------------------------------------
   // Point counter
   // ----------------------------------------
   assign cycle_end = play && (point_reg == cycle_len - 8'h01);

   always_ff @(posedge clock) begin
      if (!reset_n || !play || cycle_end) begin
         point_reg <= 8'h00;
      end else begin
         point_reg <= point_reg + 8'h01;
      end
   end
endmodule : wrm_engine_model

// ==== dv/wrm_run_ctrl_test.sv ====
// Self-checking testbench for the waveform run-mode controller
`timescale 1ns/1ps
module wrm_run_ctrl_test;
   import wrm_pkg::*;
   typedef struct packed {
      logic [2:0] what;
      logic [19:0] val;
   } wrm_note_s;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   wrm_cfg_s cfg;
   wrm_func_e func_mode;
   logic [TRC_W-1:0] trace_select;
   logic trace_select_wr;
   logic [LVL_W-1:0] amplitude_mv;
   logic signed [LVL_W-1:0] offset_mv;
   wrm_trig_s trig_in;
   logic cycle_end, play, settings_conflict;
   wrm_hold_e hold_sel;
   wrm_func_e func_active;
   logic [TRC_W-1:0] trace_active;
   wrm_mode_e run_mode;
   logic [7:0] eng_len = 8'h04;
   logic [19:0] measured;
   int bad_count = 0;
   int compares = 0;
   wrm_note_s notes[$];
   int lv_amp[4] = '{16000, 16002, 0, 2};
   int lv_off[4] = '{0, 0, -8000, -8000};
   wrm_src_e bt_src[4] = '{WRM_SRC_SW, WRM_SRC_EXT, WRM_SRC_BP, WRM_SRC_INT};
   logic bt_neg[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
   int bt_cnt[4] = '{0, 3, 2, 1};

   initial begin
      forever #4 clock = ~clock;
   end

   wrm_run_ctrl DUT (.clock(clock), .reset_n(reset_n), .cfg(cfg), .func_mode(func_mode),
      .trace_select(trace_select), .trace_select_wr(trace_select_wr),
      .amplitude_mv(amplitude_mv), .offset_mv(offset_mv), .trig_in(trig_in),
      .cycle_end(cycle_end), .play(play), .hold_sel(hold_sel), .func_active(func_active),
      .trace_active(trace_active), .run_mode(run_mode), .settings_conflict(settings_conflict));

   wrm_engine_model engine (.clock(clock), .reset_n(reset_n), .play(play),
      .cycle_len(eng_len), .cycle_end(cycle_end));

   // ----------------------------------------
   // Output monitor
   // ----------------------------------------
   initial begin : monitor
      wrm_note_s n;
      logic [19:0] got;
      forever begin
         wait (notes.size() != 0);
         n = notes[0];
         case (n.what)
            3'h0: got = {19'h0, play};
            3'h1: got = {18'h0, hold_sel};
            3'h2: got = {15'h0, run_mode};
            3'h3: got = {19'h0, settings_conflict};
            3'h4: got = {18'h0, func_active};
            3'h5: got = {4'h0, trace_active};
            default: got = measured;
         endcase
         compares++;
         if (got !== n.val) begin
            bad_count++;
            $display("[ERR] %0t kind %0d got %0h expected %0h", $time, n.what, got, n.val);
         end
         notes.delete(0);
      end
   end

   // ----------------------------------------
   // Driver tasks
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc

   task automatic check(input logic [2:0] what, input logic [19:0] val);
      notes.push_back('{what, val});
      wait (notes.size() == 0);
   endtask : check

   task automatic wait_play(input logic v);
      for (int i = 0; i < 80 && play !== v; i++) cyc(1);
      check(3'h0, {19'h0, v});
   endtask : wait_play

   // Counts cycle ends; optionally stops once output goes idle
   task automatic count_ends(input int n, input logic stop);
      measured = '0;
      for (int i = 0; i < n; i++) begin
         cyc(1);
         if (cycle_end === 1'b1) measured++;
         if (stop && play === 1'b0 && measured != 0) break;
      end
   endtask : count_ends

   // Software pulse, or hardware edge away from idle and back
   task automatic fire(input wrm_src_e s);
      case (s)
         WRM_SRC_SW: trig_in.sw_trig = 1'b1;
         WRM_SRC_EXT: trig_in.ext_trig = ~trig_in.ext_trig;
         WRM_SRC_INT: trig_in.int_trig = ~trig_in.int_trig;
         default: trig_in.bp_trig = ~trig_in.bp_trig;
      endcase
      cyc(1);
      trig_in.sw_trig = 1'b0;
      if (s != WRM_SRC_SW) begin
         cyc(4);
         trig_in.ext_trig ^= (s == WRM_SRC_EXT);
         trig_in.int_trig ^= (s == WRM_SRC_INT);
         trig_in.bp_trig ^= (s == WRM_SRC_BP);
      end
   endtask : fire

   task automatic print_verdict;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict

   initial begin : watchdog
      #400000;
      bad_count++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin : main
      int a, o, e;
      cfg = '0;
      cfg.cont_on = 1'b1;
      cfg.source = WRM_SRC_SW;
      cfg.retrig_delay = 32'h00000006;
      func_mode = WRM_FN_STD;
      trace_select = 16'h0001;
      trace_select_wr = 1'b0;
      amplitude_mv = 16'h0000;
      offset_mv = 16'sh0000;
      trig_in = '0;
      void'($urandom(32'h63c9));
      eng_len = 8'($urandom_range(4, 8));
      cyc(4);
      reset_n = 1'b1;
      cyc(1);
      check(3'h0, 20'h1);
      check(3'h1, {18'h0, WRM_HOLD_NONE});
      check(3'h5, {4'h0, TRACE_DEF});
      check(3'h4, {18'h0, WRM_FN_STD});
      check(3'h2, {15'h0, WRM_CONT});
      count_ends(30, 1'b0);
      check(3'h6, 20'(30 / eng_len) - 20'h1 <= measured ? measured : 20'hfffff);
      $display("test reset_continuous done");
      for (int i = 0; i < 12; i++) begin
         a = (i < 4) ? lv_amp[i] : int'($urandom_range(0, 18000));
         o = (i < 4) ? lv_off[i] : int'($urandom_range(0, 18000)) - 9000;
         amplitude_mv = 16'(a);
         offset_mv = 16'(o);
         cyc(2);
         e = (a / 2 + (o < 0 ? -o : o)) > 8000;
         check(3'h3, 20'(e));
      end
      amplitude_mv = 16'h0000;
      offset_mv = 16'sh0000;
      func_mode = WRM_FN_ARB;
      trace_select = 16'($urandom_range(2, 16'hffff));
      trace_select_wr = 1'b1;
      cyc(1);
      trace_select_wr = 1'b0;
      cyc(2);
      check(3'h4, {18'h0, WRM_FN_ARB});
      check(3'h5, {4'h0, trace_select});
      func_mode = WRM_FN_SEQ;
      cyc(2);
      check(3'h4, {18'h0, WRM_FN_SEQ});
      func_mode = WRM_FN_STD;
      $display("test levels_function done");
      cfg.cont_on = 1'b0;
      cyc(1);
      check(3'h2, {15'h0, WRM_TRIG});
      wait_play(1'b0);
      fire(WRM_SRC_INT);
      count_ends(20, 1'b0);
      check(3'h6, 20'h0);
      fire(WRM_SRC_SW);
      cyc(1);
      fire(WRM_SRC_SW);
      count_ends(100, 1'b1);
      check(3'h6, 20'h1);
      check(3'h1, {18'h0, WRM_HOLD_FIRST});
      $display("test triggered done");
      cfg.burst_on = 1'b1;
      for (int i = 0; i < 4; i++) begin
         // Source first, so idle pin moves are wrong-way edges
         cfg.source = bt_src[i];
         cfg.slope_neg = bt_neg[i];
         cfg.burst_count = 20'(bt_cnt[i]);
         trig_in.ext_trig = bt_neg[i];
         trig_in.int_trig = bt_neg[i];
         trig_in.bp_trig = bt_neg[i];
         cyc(6);
         check(3'h2, {15'h0, WRM_BURST});
         fire(bt_src[i]);
         if (bt_src[i] == WRM_SRC_SW) begin
            cyc(1);
            fire(WRM_SRC_SW);
         end
         count_ends(300, 1'b1);
         check(3'h6, (bt_cnt[i] == 0) ? 20'h1 : 20'(bt_cnt[i]));
         check(3'h1, {18'h0, WRM_HOLD_FIRST});
      end
      cfg.burst_on = 1'b0;
      cyc(1);
      check(3'h2, {15'h0, WRM_TRIG});
      $display("test burst done");
      cfg.source = WRM_SRC_SW;
      cfg.slope_neg = 1'b0;
      trig_in = '0;
      cfg.retrig_on = 1'b1;
      cyc(5);
      fire(WRM_SRC_SW);
      for (int i = 0; i < 80 && cycle_end !== 1'b1; i++) cyc(1);
      cyc(1);
      measured = '0;
      for (int i = 0; i < 80 && play !== 1'b1; i++) begin
         cyc(1);
         measured++;
      end
      measured = {19'h0, measured >= 20'h6 && measured <= 20'h8};
      check(3'h6, 20'h1);
      cfg.burst_on = 1'b1;
      cfg.burst_count = 20'h00002;
      count_ends(40 * eng_len, 1'b0);
      measured = {19'h0, measured > 20'h4};
      check(3'h6, 20'h1);
      cfg.burst_on = 1'b0;
      cfg.retrig_on = 1'b0;
      cyc(1);
      check(3'h2, {15'h0, WRM_TRIG});
      wait_play(1'b0);
      count_ends(40, 1'b0);
      check(3'h6, 20'h0);
      $display("test retrigger done");
      cfg.gated_on = 1'b1;
      cyc(1);
      check(3'h2, {15'h0, WRM_GATED});
      fire(WRM_SRC_SW);
      count_ends(20, 1'b0);
      check(3'h6, 20'h0);
      cfg.source = WRM_SRC_EXT;
      cyc(1);
      fire(WRM_SRC_EXT);
      count_ends(40, 1'b0);
      measured = {19'h0, measured >= 20'h3};
      check(3'h6, 20'h1);
      fire(WRM_SRC_EXT);
      wait_play(1'b0);
      check(3'h1, {18'h0, WRM_HOLD_LAST});
      cfg.gate_level = 1'b1;
      cyc(10);
      check(3'h0, 20'h0);
      trig_in.ext_trig = 1'b1;
      wait_play(1'b1);
      trig_in.ext_trig = 1'b0;
      wait_play(1'b0);
      check(3'h1, {18'h0, WRM_HOLD_LAST});
      cfg.gated_on = 1'b0;
      cyc(1);
      check(3'h2, {15'h0, WRM_TRIG});
      cfg.cont_on = 1'b1;
      wait_play(1'b1);
      check(3'h2, {15'h0, WRM_CONT});
      $display("test gated_resume done");
      print_verdict();
   end
endmodule : wrm_run_ctrl_test

// ==== rtl/wrm_level_check.sv ====
// Amplitude and offset range check with registered result
`timescale 1ns/1ps
module wrm_level_check
   import wrm_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Requested levels in millivolts
   input wire logic [LVL_W-1:0] amplitude_mv,
   input wire logic signed [LVL_W-1:0] offset_mv,
   // Result
   output logic conflict
);
   typedef struct packed {
      logic conflict;
   } wrm_lc_s;

   wrm_lc_s st_reg, st_next;
   logic [LVL_W:0] off_mag;
   logic [LVL_W+1:0] total;

   always_comb begin
      off_mag = offset_mv[LVL_W-1] ? {1'b0, -offset_mv} : {1'b0, offset_mv};
      total = {2'b00, amplitude_mv[LVL_W-1:1]} + {1'b0, off_mag};
      st_next.conflict = total > {1'b0, PEAK_MV};
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign conflict = st_reg.conflict;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   conflict_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
      conflict == $past(total > {1'b0, PEAK_MV}))
      else $error("conflict flag wrong");
endmodule : wrm_level_check

// ==== rtl/wrm_pkg.sv ====
// Package of constants and types for the waveform run-mode controller
package wrm_pkg;
   // ----------------------------------------
   // Widths and limits
   // ----------------------------------------
   localparam int LVL_W = 16;          // Millivolt fields
   localparam int CNT_W = 20;
   localparam int DLY_W = 32;
   localparam int TRC_W = 16;
   localparam logic [LVL_W:0] PEAK_MV = 17'h01f40; // 8000 mV peak
   localparam logic [CNT_W-1:0] BURST_MIN = 20'h00001;
   localparam logic [CNT_W-1:0] BURST_MAX = 20'hf4240; // One million
   localparam logic [TRC_W-1:0] TRACE_DEF = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
   localparam logic [DLY_W-1:0] DLY_ONE = 32'h00000001;

   // ----------------------------------------
   // Enumerations
   // ----------------------------------------
   typedef enum logic [1:0] {
      WRM_FN_STD = 2'h0,
      WRM_FN_ARB = 2'h1,
      WRM_FN_SEQ = 2'h2
   } wrm_func_e;

   typedef enum logic [1:0] {
      WRM_SRC_EXT = 2'h0,
      WRM_SRC_INT = 2'h1,
      WRM_SRC_BP = 2'h2,
      WRM_SRC_SW = 2'h3
   } wrm_src_e;

   typedef enum logic [4:0] {
      WRM_CONT = 5'h01,
      WRM_TRIG = 5'h02,
      WRM_RETRIG = 5'h04,
      WRM_GATED = 5'h08,
      WRM_BURST = 5'h10
   } wrm_mode_e;

   typedef enum logic [3:0] {
      WRM_IDLE = 4'h1,
      WRM_RUN = 4'h2,
      WRM_DELAY = 4'h4,
      WRM_STOP = 4'h8
   } wrm_state_e;

   typedef enum logic [1:0] {
      WRM_HOLD_FIRST = 2'h0,
      WRM_HOLD_LAST = 2'h1,
      WRM_HOLD_NONE = 2'h2
   } wrm_hold_e;

   // ----------------------------------------
   // Carried groups
   // ----------------------------------------
   typedef struct packed {
      logic cont_on;
      logic retrig_on;
      logic gated_on;
      logic burst_on;
      logic gate_level;      // 1 level gating, 0 transition gating
      logic slope_neg;       // Active edge or open level selection
      wrm_src_e source;
      logic [CNT_W-1:0] burst_count;
      logic [DLY_W-1:0] retrig_delay;
   } wrm_cfg_s;

   typedef struct packed {
      logic ext_trig;
      logic int_trig;
      logic bp_trig;
      logic sw_trig;          // One-cycle pulse from host logic
   } wrm_trig_s;
endpackage : wrm_pkg

// ==== rtl/wrm_run_ctrl.sv ====
// Run-mode controller top: mode selection, trigger, gate and burst sequencing
`timescale 1ns/1ps
module wrm_run_ctrl
   import wrm_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Mode settings from host
   input wire wrm_cfg_s cfg,
   input wire wrm_func_e func_mode,
   input wire logic [TRC_W-1:0] trace_select,
   input wire logic trace_select_wr,
   input wire logic [LVL_W-1:0] amplitude_mv,
   input wire logic signed [LVL_W-1:0] offset_mv,
   // Trigger inputs
   input wire wrm_trig_s trig_in,
   // Playback engine handshake
   input wire logic cycle_end,
   // Outputs to playback engine
   output logic play,
   output wrm_hold_e hold_sel,
   output wrm_func_e func_active,
   output logic [TRC_W-1:0] trace_active,
   output wrm_mode_e run_mode,
   output logic settings_conflict
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] ext_sync;
      logic [2:0] int_sync;
      logic [2:0] bp_sync;
      wrm_state_e state;
      wrm_hold_e hold;
      logic gate_open;
      logic [CNT_W-1:0] cycles_left;
      logic [DLY_W-1:0] delay_left;
      logic [TRC_W-1:0] trace;
      wrm_func_e func;
      logic [CNT_W-1:0] burst_len;
   } wrm_st_s;

   wrm_st_s st_reg, st_next;
   wrm_mode_e mode;
   logic hw_level, hw_prev, hw_edge, trig_event, gate_close;

   // Hardware edge in the programmed direction
   function automatic logic edge_of(input logic cur, input logic prev, input logic neg);
      edge_of = neg ? (prev && !cur) : (!prev && cur);
   endfunction : edge_of

   // Clamp burst count to the legal range
   function automatic logic [CNT_W-1:0] clamp_count(input logic [CNT_W-1:0] c);
      if (c < BURST_MIN) begin
         clamp_count = BURST_MIN;
      end else if (c > BURST_MAX) begin
         clamp_count = BURST_MAX;
      end else begin
         clamp_count = c;
      end
   endfunction : clamp_count

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   always_comb begin
      if (cfg.cont_on) begin
         mode = WRM_CONT;
      end else if (cfg.gated_on) begin
         mode = WRM_GATED;
      end else if (cfg.burst_on) begin
         mode = WRM_BURST;
      end else if (cfg.retrig_on) begin
         mode = WRM_RETRIG;
      end else begin
         mode = WRM_TRIG;
      end
   end

   // ----------------------------------------
   // Trigger selection
   // ----------------------------------------
   always_comb begin
      // Second synchroniser stage and one history stage per input
      case (cfg.source)
         WRM_SRC_EXT: begin
            hw_level = st_reg.ext_sync[1];
            hw_prev = st_reg.ext_sync[2];
         end
         WRM_SRC_INT: begin
            hw_level = st_reg.int_sync[1];
            hw_prev = st_reg.int_sync[2];
         end
         WRM_SRC_BP: begin
            hw_level = st_reg.bp_sync[1];
            hw_prev = st_reg.bp_sync[2];
         end
         default: begin
            hw_level = 1'b0;
            hw_prev = 1'b0;
         end
      endcase
      hw_edge = (cfg.source != WRM_SRC_SW) && edge_of(hw_level, hw_prev, cfg.slope_neg);
      trig_event = (cfg.source == WRM_SRC_SW) ? trig_in.sw_trig : hw_edge;
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.ext_sync = {st_reg.ext_sync[1:0], trig_in.ext_trig};
      st_next.int_sync = {st_reg.int_sync[1:0], trig_in.int_trig};
      st_next.bp_sync = {st_reg.bp_sync[1:0], trig_in.bp_trig};
      gate_close = 1'b0;
      if (trace_select_wr) begin
         st_next.trace = trace_select;
      end
      st_next.func = func_mode;
      st_next.burst_len = clamp_count(cfg.burst_count);
      // Gate tracking; hardware sources only
      if (mode == WRM_GATED && cfg.source != WRM_SRC_SW) begin
         if (cfg.gate_level) begin
            st_next.gate_open = hw_level ^ cfg.slope_neg;
         end else if (hw_edge) begin
            st_next.gate_open = !st_reg.gate_open;
         end
      end else begin
         st_next.gate_open = 1'b0;
      end
      gate_close = st_reg.gate_open && !st_next.gate_open;
      if (mode == WRM_CONT) begin
         st_next.state = WRM_RUN;
         st_next.hold = WRM_HOLD_NONE;
      end else begin
         case (st_reg.state)
            WRM_IDLE: begin
               if (mode == WRM_GATED) begin
                  if (st_next.gate_open) begin
                     st_next.state = WRM_RUN;
                  end
               end else if (trig_event) begin
                  st_next.state = WRM_RUN;
                  st_next.cycles_left = (mode == WRM_BURST) ? st_reg.burst_len : CNT_ONE;
               end
            end
            WRM_RUN: begin
               if (mode == WRM_GATED) begin
                  if (gate_close) begin
                     st_next.state = WRM_STOP;
                  end
               end else if (cycle_end) begin
                  if (mode == WRM_BURST && st_reg.cycles_left > CNT_ONE) begin
                     st_next.cycles_left = st_reg.cycles_left - CNT_ONE;
                  end else if (cfg.retrig_on && cfg.retrig_delay != '0) begin
                     st_next.state = WRM_DELAY;
                     st_next.delay_left = cfg.retrig_delay;
                     st_next.hold = WRM_HOLD_FIRST;
                  end else if (cfg.retrig_on) begin
                     st_next.cycles_left = (mode == WRM_BURST) ? st_reg.burst_len : CNT_ONE;
                  end else begin
                     st_next.state = WRM_IDLE;
                     st_next.hold = WRM_HOLD_FIRST;
                  end
               end
               // Triggers while running fall through unused
            end
            WRM_DELAY: begin
               if (!cfg.retrig_on) begin
                  st_next.state = WRM_IDLE;
               end else if (st_reg.delay_left <= DLY_ONE) begin
                  st_next.state = WRM_RUN;
                  st_next.cycles_left = (mode == WRM_BURST) ? st_reg.burst_len : CNT_ONE;
               end else begin
                  st_next.delay_left = st_reg.delay_left - DLY_ONE;
               end
            end
            WRM_STOP: begin
               if (cycle_end) begin
                  st_next.state = WRM_IDLE;
                  st_next.hold = WRM_HOLD_LAST;
               end
            end
            default: begin
               st_next.state = WRM_IDLE;
            end
         endcase
         if (st_reg.state == WRM_RUN && mode != WRM_GATED && cycle_end == 1'b0) begin
            st_next.hold = st_reg.hold;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         st_reg.ext_sync <= '0;
         st_reg.int_sync <= '0;
         st_reg.bp_sync <= '0;
         st_reg.state <= WRM_RUN;
         st_reg.hold <= WRM_HOLD_NONE;
         st_reg.gate_open <= 1'b0;
         st_reg.cycles_left <= '0;
         st_reg.delay_left <= '0;
         st_reg.trace <= TRACE_DEF;
         st_reg.func <= WRM_FN_STD;
         st_reg.burst_len <= BURST_MIN;
      end else begin
         st_reg <= st_next;
      end
   end

   wrm_level_check u_level (
      .clock(clock),
      .reset_n(reset_n),
      .amplitude_mv(amplitude_mv),
      .offset_mv(offset_mv),
      .conflict(settings_conflict)
   );

   assign play = (st_reg.state == WRM_RUN) || (st_reg.state == WRM_STOP);
   assign hold_sel = st_reg.hold;
   assign func_active = st_reg.func;
   assign trace_active = st_reg.trace;
   assign run_mode = mode;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   cont_runs_a: assert property (@(posedge clock) disable iff (!reset_n)
      mode == WRM_CONT |=> play)
      else $error("continuous mode not playing");
   reset_cont_a: assert property (@(posedge clock)
      !reset_n |=> st_reg.state == WRM_RUN)
      else $error("reset did not start running");
   trig_default_a: assert property (@(posedge clock)
      !cfg.cont_on && !cfg.retrig_on && !cfg.gated_on && !cfg.burst_on
      |-> mode == WRM_TRIG)
      else $error("default interrupted mode wrong");
   trig_once_a: assert property (@(posedge clock) disable iff (!reset_n)
      mode == WRM_TRIG && $past(mode) == WRM_TRIG && st_reg.state == WRM_RUN && cycle_end
      |=> st_reg.state == WRM_IDLE && hold_sel == WRM_HOLD_FIRST)
      else $error("triggered mode did not stop after one cycle");
   idle_wait_a: assert property (@(posedge clock) disable iff (!reset_n)
      mode != WRM_CONT && mode != WRM_GATED && st_reg.state == WRM_IDLE && !trig_event
      |=> !play)
      else $error("started without trigger");
   retrig_delay_a: assert property (@(posedge clock) disable iff (!reset_n)
      st_reg.state == WRM_DELAY && cfg.retrig_on && st_reg.delay_left > DLY_ONE
      |=> st_reg.state == WRM_DELAY && st_reg.delay_left == $past(st_reg.delay_left) - DLY_ONE)
      else $error("re-trigger delay not counting");
   gate_sw_a: assert property (@(posedge clock) disable iff (!reset_n)
      cfg.source == WRM_SRC_SW |=> !st_reg.gate_open)
      else $error("software source opened gate");
   gate_last_a: assert property (@(posedge clock) disable iff (!reset_n)
      st_reg.state == WRM_STOP && cycle_end && mode == WRM_GATED
      |=> hold_sel == WRM_HOLD_LAST)
      else $error("gate close did not hold last point");
   burst_range_a: assert property (@(posedge clock) disable iff (!reset_n)
      st_reg.burst_len >= BURST_MIN && st_reg.burst_len <= BURST_MAX)
      else $error("burst length out of range");
   busy_ignore_a: assert property (@(posedge clock) disable iff (!reset_n)
      st_reg.state == WRM_RUN && mode == WRM_BURST && $past(mode) == WRM_BURST
      && !cycle_end && trig_event |=> st_reg.cycles_left == $past(st_reg.cycles_left))
      else $error("trigger disturbed running burst");
   trace_load_a: assert property (@(posedge clock) disable iff (!reset_n)
      trace_select_wr |=> trace_active == $past(trace_select))
      else $error("trace selection not loaded");
   func_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
      1'b1 |=> func_active == $past(func_mode))
      else $error("function selection not applied");
   burst_load_a: assert property (@(posedge clock) disable iff (!reset_n)
      mode == WRM_BURST && st_reg.state == WRM_IDLE && trig_event
      |=> play && st_reg.cycles_left == $past(st_reg.burst_len))
      else $error("burst did not start with programmed count");
   cont_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
      mode == WRM_CONT |=> hold_sel == WRM_HOLD_NONE)
      else $error("continuous mode holding a level");
   retrig_go_a: assert property (@(posedge clock) disable iff (!reset_n)
      st_reg.state == WRM_DELAY && mode != WRM_CONT && cfg.retrig_on
      && st_reg.delay_left <= DLY_ONE |=> st_reg.state == WRM_RUN)
      else $error("re-trigger did not restart output");
   retrig_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
      st_reg.state == WRM_DELAY && mode != WRM_CONT && !cfg.retrig_on
      |=> st_reg.state == WRM_IDLE)
      else $error("re-trigger off did not stop");
   gate_level_a: assert property (@(posedge clock) disable iff (!reset_n)
      mode == WRM_GATED && cfg.source != WRM_SRC_SW && cfg.gate_level
      |=> st_reg.gate_open == $past(hw_level ^ cfg.slope_neg))
      else $error("level gate state wrong");

   // ----------------------------------------
   // Coverage
   // ----------------------------------------
   burst_start_c: cover property (@(posedge clock) disable iff (!reset_n)
      mode == WRM_BURST && st_reg.state == WRM_IDLE && trig_event);
   retrig_c: cover property (@(posedge clock) disable iff (!reset_n)
      st_reg.state == WRM_DELAY ##1 st_reg.state == WRM_RUN);
   gate_c: cover property (@(posedge clock) disable iff (!reset_n)
      st_reg.state == WRM_STOP ##[1:50] st_reg.state == WRM_IDLE);
   trig_run_c: cover property (@(posedge clock) disable iff (!reset_n)
      mode == WRM_TRIG && st_reg.state == WRM_IDLE && trig_event);
   level_gate_c: cover property (@(posedge clock) disable iff (!reset_n)
      mode == WRM_GATED && cfg.gate_level && st_reg.gate_open);
endmodule : wrm_run_ctrl
